// ===== core/rfac_consts.svh
// Purpose: constants for the frame acceptance and auto-reply control block
// Assumes: 50 MHz mclk, 16 us receive symbol
// Notes: offsets are byte addresses on the plain register port
`ifndef RFAC_CONSTS_SVH
`define RFAC_CONSTS_SVH

`define RFAC_ADDR_W 9
`define RFAC_OFS_SENS 9'h155
`define RFAC_OFS_REPLY 9'h157
`define RFAC_OFS_IRQ_STAT 9'h160
`define RFAC_OFS_IRQ_MASK 9'h161
`define RFAC_OFS_MISC 9'h162
`define RFAC_OFS_STATUS 9'h163

`define RFAC_SENS_RST 8'h40
`define RFAC_SENS_WMASK 8'hFF
`define RFAC_REPLY_RST 8'h00
`define RFAC_REPLY_WMASK 8'h36
`define RFAC_BIT_BLOCK 7
`define RFAC_BIT_RESTART 6
`define RFAC_BIT_ROPT_HI 5
`define RFAC_BIT_ROPT_LO 4
`define RFAC_LVL_HI 3
`define RFAC_LVL_LO 0
`define RFAC_BIT_FLT_RES 5
`define RFAC_BIT_ACC_RES 4
`define RFAC_BIT_SHORT 2
`define RFAC_BIT_PROM 1
`define RFAC_BIT_SUPPRESS 0

`define RFAC_IRQ_END 0
`define RFAC_IRQ_AMATCH 1
`define RFAC_IRQ_ACK 2
`define RFAC_IRQ_ABORT 3
`define RFAC_IRQ_W 4

`define RFAC_FLOOR_DEF 8'h00
`define RFAC_LVL_STEP 8'h03
`define RFAC_CLK_NS 20
`define RFAC_SYMBOL_NS 16000
`define RFAC_SYMBOL_CYC (`RFAC_SYMBOL_NS / `RFAC_CLK_NS)
`define RFAC_LONG_SYMS 12
`define RFAC_SHORT_SYMS 2
`define RFAC_LONG_TURN_CYC (`RFAC_LONG_SYMS * `RFAC_SYMBOL_CYC)
`define RFAC_SHORT_TURN_CYC (`RFAC_SHORT_SYMS * `RFAC_SYMBOL_CYC)
`define RFAC_CNT_W 14

`endif

// ===== core/rfac_pkg.sv
// Purpose: types for the frame acceptance and auto-reply control block
// Assumes: receive datapath on the same clock
// Notes: constants live in rfac_consts.svh
package rfac_pkg;

    typedef enum logic [2:0] {
        ST_LISTEN = 3'b001,
        ST_RECV = 3'b010,
        ST_TURN = 3'b100
    } rfac_state_t;

    typedef struct packed {
        logic frame_detect;
        logic interferer;
        logic frame_end;
        logic fcs_ok;
        logic reserved_type;
        logic addr_match;
        logic ack_request;
        logic [7:0] rssi;
    } rfac_rx_in_t;

    typedef struct packed {
        logic rx_start;
        logic rx_abort;
        logic frame_end_evt;
        logic address_match_event;
        logic ack_start;
        logic checksum_ok;
    } rfac_rx_out_t;

endpackage : rfac_pkg

// ===== core/rfac_ctrl.sv
// Purpose: frame acceptance, filtering and auto-reply timing control
// Assumes: rx inputs are one-cycle pulses from logic on mclk
// Notes: long turnaround counts are parameters so simulation may shorten them
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "rfac_consts.svh"

// What this block does
// R1: block bit stops new frames, not current
// R2: block applies whatever threshold level holds
// R3: restart bit abandons frame on interferer
// R4: nonzero level drops frames below threshold
// R5: level zero accepts every valid frame
// R6: reserved bits read zero, writes ignored
// R7: software sets filter only with accept set
// R8: filter set: reserved frames address filtered
// R9: filter clear: reserved frames checked FCS only
// R10: accept set: reserved frames end on FCS
// R11: both set: reserved treated as data
// R12: both set: passing reserved frame acked unless suppressed
// R13: ack after 12 or 2 symbols
// R14: same delay used in slotted acknowledgment
// R15: promiscuous: every valid PHR frame ends
// R16: promiscuous: checksum ok flag updated
// R17: promiscuous: passing frame still acked
// R18: block and level sampled at detection
module rfac_ctrl #(
    parameter int LONG_TURN_CYC = `RFAC_LONG_TURN_CYC,
    parameter int SHORT_TURN_CYC = `RFAC_SHORT_TURN_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [`RFAC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic rx_on,
    input wire logic auto_reply_receive,
    input wire logic slotted_ack,
    input wire rfac_pkg::rfac_rx_in_t rx_in,
    output rfac_pkg::rfac_rx_out_t rx_out,
    output logic [1:0] restart_option,
    output logic irq
);

    logic [7:0] sens_r;
    logic [7:0] reply_r;
    logic [`RFAC_IRQ_W-1:0] irq_stat_r;
    logic [`RFAC_IRQ_W-1:0] irq_mask_r;
    logic reply_suppress_r;
    logic checksum_ok_r;
    logic [7:0] reg_rdata_r;
    rfac_pkg::rfac_state_t state_r;
    logic [`RFAC_CNT_W-1:0] turn_cnt_r;
    logic [3:0] lvl_smp_r;
    logic rx_start_r;
    logic rx_abort_r;
    logic end_evt_r;
    logic amatch_evt_r;
    logic ack_start_r;

    logic wr_sens;
    logic wr_reply;
    logic wr_stat;
    logic wr_mask;
    logic wr_misc;
    logic [3:0] lvl;
    logic [7:0] threshold;
    logic strong_enough;
    logic accept_frame;
    logic flt_res;
    logic acc_res;
    logic prom;
    logic addr_ok;
    logic data_like;
    logic end_evt_nxt;
    logic amatch_nxt;
    logic ack_nxt;
    logic abort_nxt;
    logic [`RFAC_IRQ_W-1:0] irq_set;

    // register decode
    always_comb begin
        wr_sens = 1'b0;
        wr_reply = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        wr_misc = 1'b0;
        if (reg_we && reg_addr == `RFAC_OFS_SENS) begin
            wr_sens = 1'b1;
        end else if (reg_we && reg_addr == `RFAC_OFS_REPLY) begin
            wr_reply = 1'b1;
        end else if (reg_we && reg_addr == `RFAC_OFS_IRQ_STAT) begin
            wr_stat = 1'b1;
        end else if (reg_we && reg_addr == `RFAC_OFS_IRQ_MASK) begin
            wr_mask = 1'b1;
        end else if (reg_we && reg_addr == `RFAC_OFS_MISC) begin
            wr_misc = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sens_r <= `RFAC_SENS_RST;
        end else if (wr_sens) begin
            sens_r <= reg_wdata & `RFAC_SENS_WMASK;
        end
    end

    // reserved bits never stored, so they read back as zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            reply_r <= `RFAC_REPLY_RST;
        end else if (wr_reply) begin
            reply_r <= reg_wdata & `RFAC_REPLY_WMASK; // R6
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_mask_r <= '0;
        end else if (wr_mask) begin
            irq_mask_r <= reg_wdata[`RFAC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reply_suppress_r <= 1'b0;
        end else if (wr_misc) begin
            reply_suppress_r <= reg_wdata[`RFAC_BIT_SUPPRESS];
        end
    end

    // a new event wins over a write-one-to-clear in the same cycle
    assign irq_set = {abort_nxt, ack_nxt, amatch_nxt, end_evt_nxt};

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? reg_wdata[`RFAC_IRQ_W-1:0] : '0)) | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else if (!reg_re) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_addr == `RFAC_OFS_SENS) begin
            reg_rdata_r <= sens_r;
        end else if (reg_addr == `RFAC_OFS_REPLY) begin
            reg_rdata_r <= reply_r; // R6
        end else if (reg_addr == `RFAC_OFS_IRQ_STAT) begin
            reg_rdata_r <= {4'h0, irq_stat_r};
        end else if (reg_addr == `RFAC_OFS_IRQ_MASK) begin
            reg_rdata_r <= {4'h0, irq_mask_r};
        end else if (reg_addr == `RFAC_OFS_MISC) begin
            reg_rdata_r <= {7'h00, reply_suppress_r};
        end else if (reg_addr == `RFAC_OFS_STATUS) begin
            // level held for the frame last taken, not the live field
            reg_rdata_r <= {1'b0, lvl_smp_r, state_r}; // R18
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign restart_option = {sens_r[`RFAC_BIT_ROPT_HI], sens_r[`RFAC_BIT_ROPT_LO]};

    // acceptance at detection
    assign lvl = sens_r[`RFAC_LVL_HI:`RFAC_LVL_LO];
    // the subtraction wraps at lvl zero, where strong_enough ignores threshold
    assign threshold = `RFAC_FLOOR_DEF + `RFAC_LVL_STEP * ({4'h0, lvl} - 8'h01); // R4
    assign strong_enough = (lvl == 4'h0) || (rx_in.rssi > threshold); // R4 R5
    // block overrides acceptance regardless of level
    assign accept_frame = rx_on && rx_in.frame_detect
        && !sens_r[`RFAC_BIT_BLOCK] && strong_enough; // R1 R2 R18

    // filtering at frame end
    // filter bit only meaningful together with accept bit
    assign acc_res = reply_r[`RFAC_BIT_ACC_RES];
    assign flt_res = reply_r[`RFAC_BIT_FLT_RES] && acc_res; // R7
    assign prom = reply_r[`RFAC_BIT_PROM] && auto_reply_receive;
    assign data_like = !rx_in.reserved_type || flt_res; // R11
    assign addr_ok = rx_in.reserved_type ? (!flt_res || rx_in.addr_match) // R8 R9
        : rx_in.addr_match;

    always_comb begin
        end_evt_nxt = 1'b0;
        amatch_nxt = 1'b0;
        ack_nxt = 1'b0;
        abort_nxt = 1'b0;
        if (state_r == rfac_pkg::ST_RECV) begin
            if (sens_r[`RFAC_BIT_RESTART] && rx_in.interferer) begin
                abort_nxt = 1'b1; // R3
            end else if (rx_in.frame_end) begin
                if (prom) begin
                    end_evt_nxt = 1'b1; // R15
                end else if (!auto_reply_receive) begin
                    end_evt_nxt = !rx_in.reserved_type || acc_res;
                end else if (rx_in.reserved_type) begin
                    end_evt_nxt = acc_res && rx_in.fcs_ok && addr_ok; // R10
                end else begin
                    end_evt_nxt = rx_in.fcs_ok && rx_in.addr_match;
                end
                if (auto_reply_receive && data_like && rx_in.addr_match
                    && (!rx_in.reserved_type || acc_res)) begin
                    amatch_nxt = 1'b1; // R11
                end
                if (auto_reply_receive && rx_in.ack_request && rx_in.fcs_ok
                    && data_like && rx_in.addr_match
                    && (!rx_in.reserved_type || acc_res) && !reply_suppress_r) begin
                    ack_nxt = 1'b1; // R12 R17
                end
            end
        end
    end

    // state sequencing
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= rfac_pkg::ST_LISTEN;
        end else begin
            case (state_r)
                rfac_pkg::ST_LISTEN: begin
                    if (accept_frame) begin
                        state_r <= rfac_pkg::ST_RECV; // R1
                    end
                end
                rfac_pkg::ST_RECV: begin
                    // block bit is not looked at here: a started frame completes
                    if (abort_nxt) begin
                        state_r <= rfac_pkg::ST_LISTEN; // R3
                    end else if (ack_nxt) begin
                        state_r <= rfac_pkg::ST_TURN;
                    end else if (rx_in.frame_end) begin
                        state_r <= rfac_pkg::ST_LISTEN;
                    end
                end
                rfac_pkg::ST_TURN: begin
                    if (turn_cnt_r == '0) begin
                        state_r <= rfac_pkg::ST_LISTEN;
                    end
                end
                default: begin
                    state_r <= rfac_pkg::ST_LISTEN;
                end
            endcase
        end
    end

    // level kept for the frame in progress; changes apply next frame
    always_ff @(posedge mclk) begin
        if (rst) begin
            lvl_smp_r <= 4'h0;
        end else if (accept_frame && state_r == rfac_pkg::ST_LISTEN) begin
            lvl_smp_r <= lvl; // R18
        end
    end

    // turnaround counter; same delay in slotted operation
    always_ff @(posedge mclk) begin
        if (rst) begin
            turn_cnt_r <= '0;
        end else if (ack_nxt) begin
            if (reply_r[`RFAC_BIT_SHORT]) begin
                turn_cnt_r <= `RFAC_CNT_W'(SHORT_TURN_CYC - 1); // R13 R14
            end else begin
                turn_cnt_r <= `RFAC_CNT_W'(LONG_TURN_CYC - 1); // R13 R14
            end
        end else if (state_r == rfac_pkg::ST_TURN && turn_cnt_r != '0) begin
            turn_cnt_r <= turn_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            checksum_ok_r <= 1'b0;
        end else if (state_r == rfac_pkg::ST_RECV && rx_in.frame_end && !abort_nxt) begin
            checksum_ok_r <= rx_in.fcs_ok; // R16
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_start_r <= 1'b0;
            rx_abort_r <= 1'b0;
            end_evt_r <= 1'b0;
            amatch_evt_r <= 1'b0;
            ack_start_r <= 1'b0;
        end else begin
            rx_start_r <= accept_frame && state_r == rfac_pkg::ST_LISTEN;
            rx_abort_r <= abort_nxt;
            end_evt_r <= end_evt_nxt;
            amatch_evt_r <= amatch_nxt;
            ack_start_r <= state_r == rfac_pkg::ST_TURN && turn_cnt_r == '0; // R13
        end
    end

    // slotted_ack has no effect on ack_start; timing is identical
    assign rx_out.rx_start = rx_start_r;
    assign rx_out.rx_abort = rx_abort_r;
    assign rx_out.frame_end_evt = end_evt_r;
    assign rx_out.address_match_event = amatch_evt_r;
    assign rx_out.ack_start = ack_start_r && (slotted_ack || auto_reply_receive || 1'b1);
    assign rx_out.checksum_ok = checksum_ok_r;

endmodule : rfac_ctrl

// ===== verif/rfac_ctrl_properties.sv
// Purpose: port checks for the acceptance and reply controller
// Assumes: register shadows follow writes seen at the port
// Notes: floor is zero, so the drop threshold is 3*(level-1)
`timescale 1ns/100ps
`include "rfac_consts.svh"
module rfac_ctrl_chk #(
    parameter int LONG_TURN_CYC = 24,
    parameter int SHORT_TURN_CYC = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [`RFAC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic auto_reply_receive,
    input wire rfac_pkg::rfac_rx_in_t rx_in,
    input wire rfac_pkg::rfac_rx_out_t rx_out
);
    logic [7:0] sens_q;
    logic [7:0] rep_q;
    logic sup_q;
    logic in_frame_r;
    logic in_rx;
    logic fe_in;
    logic [7:0] thr;
    assign in_rx = in_frame_r | rx_out.rx_start;
    assign fe_in = rx_in.frame_end & in_rx;
    assign thr = ({4'h0, sens_q[3:0]} - 8'h01) * 8'h03;
    always_ff @(posedge mclk) begin
        if (rst) begin
            sens_q <= `RFAC_SENS_RST;
            rep_q <= `RFAC_REPLY_RST;
            sup_q <= 1'b0;
        end else if (reg_we) begin
            if (reg_addr == `RFAC_OFS_SENS) sens_q <= reg_wdata;
            if (reg_addr == `RFAC_OFS_REPLY) rep_q <= reg_wdata & `RFAC_REPLY_WMASK;
            if (reg_addr == `RFAC_OFS_MISC) sup_q <= reg_wdata[0];
        end
    end
    // frame window as the design sees it, ends on frame end or abort
    always_ff @(posedge mclk) begin
        if (rst) in_frame_r <= 1'b0;
        else in_frame_r <= in_rx & ~rx_in.frame_end & ~(rx_in.interferer & sens_q[6]);
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    start_cause_a: assert property (rx_out.rx_start |-> $past(rx_in.frame_detect))
        else $error("start without detect");
    block_start_a: assert property (rx_in.frame_detect && sens_q[7] |=> !rx_out.rx_start)
        else $error("start while blocked");
    weak_drop_a: assert property (rx_in.frame_detect && sens_q[3:0] != 4'h0 && rx_in.rssi <= thr
        |=> !rx_out.rx_start)
        else $error("weak frame started");
    restart_abort_a: assert property (rx_in.interferer && sens_q[6] && in_rx |=> rx_out.rx_abort)
        else $error("no abort on interferer");
    res_fcs_end_a: assert property (fe_in && rx_in.reserved_type && rx_in.fcs_ok
        && rep_q[5:4] == 2'b01 |=> rx_out.frame_end_evt)
        else $error("reserved frame not ended");
    res_amatch_a: assert property (fe_in && rx_in.reserved_type && rx_in.fcs_ok && rx_in.addr_match
        && rep_q[5:4] == 2'b11 && auto_reply_receive |=> rx_out.address_match_event)
        else $error("no address match event");
    prom_end_a: assert property (fe_in && rep_q[1] && auto_reply_receive
        |=> rx_out.frame_end_evt && rx_out.checksum_ok == $past(rx_in.fcs_ok))
        else $error("promiscuous end wrong");
    ack_delay_a: assert property (rx_out.ack_start |-> (rep_q[2]
        ? $past(rx_out.frame_end_evt, SHORT_TURN_CYC)
        : $past(rx_out.frame_end_evt, LONG_TURN_CYC)))
        else $error("reply delay wrong");
    ack_suppress_a: assert property (rx_out.ack_start |-> !sup_q)
        else $error("reply while suppressed");
endmodule : rfac_ctrl_chk
bind rfac_ctrl rfac_ctrl_chk #(.LONG_TURN_CYC(LONG_TURN_CYC), .SHORT_TURN_CYC(SHORT_TURN_CYC))
    i_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .auto_reply_receive(auto_reply_receive), .rx_in(rx_in), .rx_out(rx_out));

// ===== verif/rfac_air_node.sv
// Purpose: remote node model, one frame per send request
// Assumes: detect one cycle after send, frame end five cycles later
// Notes: idle qualifiers show inverted values so stale data cannot pass
`timescale 1ns/100ps
module rfac_air_node (
    input wire logic mclk,
    input wire logic rst,
    input wire logic send,
    input wire logic [7:0] rssi,
    input wire logic [3:0] qual,
    input wire logic intf,
    output rfac_pkg::rfac_rx_in_t rx_in
);
    logic [2:0] cnt_r;
    logic fe;
    always_ff @(posedge mclk) begin
        if (rst) cnt_r <= 3'h0;
        else if (cnt_r != 3'h0) cnt_r <= (cnt_r == 3'h6) ? 3'h0 : cnt_r + 3'h1;
        else if (send) cnt_r <= 3'h1;
    end
    assign fe = cnt_r == 3'h6;
    assign rx_in.frame_detect = cnt_r == 3'h1;
    assign rx_in.interferer = intf && cnt_r == 3'h3;
    assign rx_in.frame_end = fe;
    assign {rx_in.fcs_ok, rx_in.reserved_type, rx_in.addr_match, rx_in.ack_request} = fe ? qual : ~qual;
    assign rx_in.rssi = rx_in.frame_detect ? rssi : ~rssi;
endmodule : rfac_air_node

// ===== verif/rfac_ctrl_tb.sv
// Purpose: self-checking bench for the acceptance and reply controller
// Assumes: turnaround shortened to 24 and 4 cycles
// Notes: a monitor counts events, cleared at each frame
`timescale 1ns/100ps
`include "rfac_consts.svh"
module rfac_ctrl_tb;
    localparam int LONG_C = 24;
    localparam int SHORT_C = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [`RFAC_ADDR_W-1:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata;
    logic auto_rx = 1'b0;
    logic slotted = 1'b0;
    logic rx_on = 1'b1;
    logic [1:0] ropt;
    rfac_pkg::rfac_rx_in_t rx_in;
    rfac_pkg::rfac_rx_out_t rx_out;
    logic irq;
    logic send = 1'b0;
    logic [7:0] rssi = 8'h00;
    logic [3:0] qual = 4'h0;
    logic intf = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int n_st, n_fe, n_am, n_ack, n_ab, t_fe, t_ack;
    always #10 mclk = ~mclk;
    rfac_ctrl #(.LONG_TURN_CYC(LONG_C), .SHORT_TURN_CYC(SHORT_C)) i_dut (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .rx_on(rx_on), .auto_reply_receive(auto_rx), .slotted_ack(slotted),
        .rx_in(rx_in), .rx_out(rx_out), .restart_option(ropt), .irq(irq));
    rfac_air_node i_node (.mclk(mclk), .rst(rst), .send(send), .rssi(rssi), .qual(qual),
        .intf(intf), .rx_in(rx_in));
    always @(posedge mclk) begin
        cyc++;
        if (rx_out.rx_start === 1'b1) n_st++;
        if (rx_out.rx_abort === 1'b1) n_ab++;
        if (rx_out.address_match_event === 1'b1) n_am++;
        if (rx_out.frame_end_evt === 1'b1) begin
            n_fe++;
            t_fe = cyc;
        end
        if (rx_out.ack_start === 1'b1) begin
            n_ack++;
            t_ack = cyc;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // blk writes the block bit while the frame is under way
    task automatic frame(input logic [7:0] r, input logic [3:0] q, input logic it, input logic blk);
        #1 n_st = 0;
        n_fe = 0;
        n_am = 0;
        n_ack = 0;
        n_ab = 0;
        @(posedge mclk);
        send <= 1'b1;
        rssi <= r;
        qual <= q;
        intf <= it;
        @(posedge mclk);
        send <= 1'b0;
        if (blk) wr(`RFAC_OFS_SENS, 8'hC0);
        repeat (40) @(posedge mclk);
        #1;
    endtask : frame
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic test_registers;
        rd(`RFAC_OFS_SENS, `RFAC_SENS_RST);
        rd(`RFAC_OFS_REPLY, `RFAC_REPLY_RST);
        wr(`RFAC_OFS_REPLY, 8'hFF);
        rd(`RFAC_OFS_REPLY, 8'h36);
        wr(`RFAC_OFS_REPLY, 8'h00);
        wr(9'h170, 8'h5A);
        rd(9'h170, 8'h00);
        wr(`RFAC_OFS_SENS, 8'h70);
        chk(ropt, 2'h3);
        wr(`RFAC_OFS_SENS, 8'h40);
        chk(ropt, 2'h0);
        $display("test registers done");
    endtask : test_registers
    task automatic test_threshold;
        frame(8'h00, 4'h0, 1'b0, 1'b0);
        chk(n_st, 1);
        wr(`RFAC_OFS_SENS, 8'h42);
        frame(8'h03, 4'h0, 1'b0, 1'b0);
        chk(n_st, 0);
        frame(8'h04, 4'h0, 1'b0, 1'b0);
        chk(n_st, 1);
        rd(`RFAC_OFS_STATUS, 8'h11);
        $display("test threshold done");
    endtask : test_threshold
    task automatic test_block;
        wr(`RFAC_OFS_SENS, 8'hC2);
        frame(8'hFF, 4'h0, 1'b0, 1'b0);
        chk(n_st, 0);
        wr(`RFAC_OFS_SENS, 8'hC0);
        frame(8'h00, 4'h0, 1'b0, 1'b0);
        chk(n_st, 0);
        wr(`RFAC_OFS_SENS, 8'h40);
        frame(8'h00, 4'h0, 1'b0, 1'b1);
        chk(n_fe, 1);
        wr(`RFAC_OFS_SENS, 8'h40);
        @(posedge mclk);
        rx_on <= 1'b0;
        frame(8'h00, 4'h0, 1'b0, 1'b0);
        chk(n_st, 0);
        @(posedge mclk);
        rx_on <= 1'b1;
        $display("test block done");
    endtask : test_block
    task automatic test_restart;
        wr(`RFAC_OFS_IRQ_STAT, 8'h0F);
        frame(8'h00, 4'h8, 1'b1, 1'b0);
        chk(n_ab, 1);
        chk(n_fe, 0);
        chk(irq, 0);
        rd(`RFAC_OFS_IRQ_STAT, 8'h08);
        wr(`RFAC_OFS_IRQ_MASK, 8'h08);
        chk(irq, 1);
        wr(`RFAC_OFS_IRQ_STAT, 8'h08);
        chk(irq, 0);
        wr(`RFAC_OFS_SENS, 8'h00);
        frame(8'h00, 4'h8, 1'b1, 1'b0);
        chk(n_ab, 0);
        wr(`RFAC_OFS_SENS, 8'h40);
        $display("test restart done");
    endtask : test_restart
    task automatic test_reserved;
        @(posedge mclk);
        auto_rx <= 1'b1;
        wr(`RFAC_OFS_REPLY, 8'h10);
        frame(8'h00, 4'hC, 1'b0, 1'b0);
        chk({n_fe[3:0], n_am[3:0]}, 8'h10);
        frame(8'h00, 4'h4, 1'b0, 1'b0);
        chk(n_fe, 0);
        wr(`RFAC_OFS_REPLY, 8'h30);
        frame(8'h00, 4'hF, 1'b0, 1'b0);
        chk({n_fe[3:0], n_am[3:0], n_ack[3:0]}, 12'h111);
        chk(t_ack - t_fe, LONG_C);
        frame(8'h00, 4'hD, 1'b0, 1'b0);
        chk({n_fe[3:0], n_ack[3:0]}, 8'h00);
        $display("test reserved done");
    endtask : test_reserved
    task automatic test_reply_delay;
        @(posedge mclk);
        slotted <= 1'b1;
        wr(`RFAC_OFS_REPLY, 8'h34);
        frame(8'h00, 4'hF, 1'b0, 1'b0);
        chk(t_ack - t_fe, SHORT_C);
        wr(`RFAC_OFS_MISC, 8'h01);
        frame(8'h00, 4'hF, 1'b0, 1'b0);
        chk({n_fe[3:0], n_ack[3:0]}, 8'h10);
        wr(`RFAC_OFS_MISC, 8'h00);
        @(posedge mclk);
        slotted <= 1'b0;
        $display("test reply delay done");
    endtask : test_reply_delay
    task automatic test_promiscuous;
        wr(`RFAC_OFS_REPLY, 8'h02);
        frame(8'h00, 4'h0, 1'b0, 1'b0);
        chk({n_fe[3:0], 3'h0, rx_out.checksum_ok}, 8'h10);
        wr(`RFAC_OFS_IRQ_STAT, 8'h0F);
        frame(8'h00, 4'hB, 1'b0, 1'b0);
        chk({n_ack[3:0], 3'h0, rx_out.checksum_ok}, 8'h11);
        rd(`RFAC_OFS_IRQ_STAT, 8'h07);
        $display("test promiscuous done");
    endtask : test_promiscuous
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        test_registers();
        test_threshold();
        test_block();
        test_restart();
        test_reserved();
        test_reply_delay();
        test_promiscuous();
        print_verdict();
    end
endmodule : rfac_ctrl_tb
